//--- shared/sacp_regs.svh
// constants of the serial converter control port
`ifndef SACP_REGS_SVH
`define SACP_REGS_SVH
`define SACP_RES_W 13
`define SACP_WORD_W 17
`define SACP_CMD_W 5
`define SACP_STAT_W 4
`define SACP_LEN_13 5'h0d
`define SACP_LEN_17 5'h11
`define SACP_LEN_9 5'h09
`define SACP_TPU_US 700
`define SACP_CLK_MHZ 200
`define SACP_PROGRAM_ENABLE_N_CCLKS 44
`define SACP_CAL_CCLKS 4944
`define SACP_ZERO_CCLKS 76
`define SACP_FIFO_DEPTH 8
`define SACP_TMR_W 18
`define SACP_CNT_W 5
`endif

//--- shared/sacp_pkg.sv
// types of the serial converter control port
package sacp_pkg;
  typedef enum logic [1:0] {
    SACP_LEN13 = 2'h0,
    SACP_LEN17 = 2'h1,
    SACP_LEN9 = 2'h2,
    SACP_LEN13B = 2'h3
  } sacp_len_e;

  typedef enum logic [1:0] {
    SACP_OP_PROGRAM_ENABLE_N = 2'h0,
    SACP_OP_CAL = 2'h1,
    SACP_OP_ZERO = 2'h2,
    SACP_OP_PDOWN = 2'h3
  } sacp_op_e;

  typedef enum logic [2:0] {
    SACP_ST_IDLE = 3'h0,
    SACP_ST_BUSY = 3'h1,
    SACP_ST_FETCH = 3'h2,
    SACP_ST_PD = 3'h3,
    SACP_ST_PWRUP = 3'h4
  } sacp_state_e;

  typedef struct packed {
    sacp_op_e op;
    logic lsb_first;
    sacp_len_e len;
  } sacp_mode_s;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic pe_n;
    logic conversion_clock;
    logic pd;
  } sacp_pins_s;
endpackage : sacp_pkg

//--- rtl/sacp_top.sv
// serial converter control port: result fifo and pin-side logic
//
// Contract
// R1: drive result pin only while selected
// R2: result and status leave on sclk falls
// R3: word length and format follow mode bits
// R4: command bit taken on sclk rise
// R5: eoc low while busy or powered down
// R6: eoc rises when a cycle completes
// R7: host holds program enable low to configure
// R8: program enable high: read only, no change
// R9: host avoids read-only access while busy
// R10: select held low: first bit at eoc rise
// R11: select toggled: first bit at select fall
// R12: host lowers select only with sclk low
// R13: select fall aborts conversion; host discards data
// R14: host gives exact clock count per sequence
// R15: thirteen clocks per sequence after power-up
// R16: expected clock count equals word length
// R17: ready flag low while shifting, then high
// R18: power down on pin, up within 700us
// R19: conversion timed from conversion clock edges
// R20: command acts only after full count
`include "sacp_regs.svh"

module sacp_fifo #(
  parameter int WIDTH = `SACP_RES_W,
  parameter int DEPTH = `SACP_FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [WIDTH-1:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [WIDTH-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("sacp_fifo: depth below two or empty width");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic room_ff;
  logic empty_ff;

  wire push = IN_VALID && room_ff;
  wire pop = OUT_READY && !empty_ff;
  wire [AW:0] nxt_cnt = cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
  wire [AW-1:0] nxt_wr =
    (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + AW'(1);
  wire [AW-1:0] nxt_rd =
    (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + AW'(1);

  assign IN_READY = room_ff;
  assign OUT_VALID = !empty_ff;
  assign OUT_DATA = mem[rd_ptr_ff];

  // storage holds no reset so it maps onto plain ram
  always_ff @(posedge CLK) begin
    if (CE && push) begin
      mem[wr_ptr_ff] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      room_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else if (CE) begin
      if (push) begin
        wr_ptr_ff <= nxt_wr;
      end
      if (pop) begin
        rd_ptr_ff <= nxt_rd;
      end
      cnt_ff <= nxt_cnt;
      room_ff <= (nxt_cnt != FULL_CNT);
      empty_ff <= (nxt_cnt == '0);
    end
  end
endmodule : sacp_fifo

module sacp_top #(
  parameter int FIFO_DEPTH = `SACP_FIFO_DEPTH,
  parameter int PROGRAM_ENABLE_N_CCLKS = `SACP_PROGRAM_ENABLE_N_CCLKS,
  parameter int CAL_CCLKS = `SACP_CAL_CCLKS,
  parameter int ZERO_CCLKS = `SACP_ZERO_CCLKS,
  parameter int PWRUP_CYCLES = `SACP_TPU_US * `SACP_CLK_MHZ
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic COMMAND_IN_PIN,
  input wire logic PROGRAM_ENABLE_N,
  input wire logic CONVERSION_CLOCK,
  input wire logic POWER_DOWN_PIN,
  input wire logic [`SACP_RES_W-1:0] SAMPLE_DATA,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  output logic RESULT_O,
  output logic RESULT_OE,
  output logic EOC,
  output logic OUTPUT_READY_FLAG
);
  localparam int TMR_MAX = 2 ** `SACP_TMR_W;

  generate
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= TMR_MAX ||
        PROGRAM_ENABLE_N_CCLKS < 1 || PROGRAM_ENABLE_N_CCLKS >= TMR_MAX ||
        CAL_CCLKS < 1 || CAL_CCLKS >= TMR_MAX ||
        ZERO_CCLKS < 1 || ZERO_CCLKS >= TMR_MAX) begin : g_bad
      $error("sacp_top: cycle count outside timer range");
    end
  endgenerate

  // expected clocks per sequence for a length code
  function automatic logic [`SACP_CNT_W-1:0] len_of(
    input sacp_pkg::sacp_len_e len
  );
    case (len)
      sacp_pkg::SACP_LEN17: len_of = `SACP_LEN_17;
      sacp_pkg::SACP_LEN9: len_of = `SACP_LEN_9;
      default: len_of = `SACP_LEN_13;
    endcase
  endfunction : len_of

  // left aligned output word, bit order per mode
  function automatic logic [`SACP_WORD_W-1:0] frame(
    input sacp_pkg::sacp_mode_s mode,
    input logic [`SACP_RES_W-1:0] res
  );
    logic [`SACP_WORD_W-1:0] w;
    logic [`SACP_WORD_W-1:0] r;
    logic [`SACP_CNT_W-1:0] n;
    w = '0;
    r = '0;
    n = len_of(mode.len);
    if (mode.len == sacp_pkg::SACP_LEN17) begin
      w = {mode.op, mode.len, res};
    end else begin
      w = {res, `SACP_STAT_W'(0)};
    end
    for (int i = 0; i < `SACP_WORD_W; i++) begin
      if (i < int'(n)) begin
        r[`SACP_WORD_W-1-i] = w[`SACP_WORD_W - int'(n) + i];
      end
    end
    frame = mode.lsb_first ? r : w;
  endfunction : frame

  // two flops on every pin, third stage only for edge finding
  sacp_pkg::sacp_pins_s raw;
  sacp_pkg::sacp_pins_s s1_ff;
  sacp_pkg::sacp_pins_s s2_ff;
  sacp_pkg::sacp_pins_s s3_ff;

  assign raw = '{cs_n: CS_N, sclk: SCLK, din: COMMAND_IN_PIN,
                 pe_n: PROGRAM_ENABLE_N, conversion_clock: CONVERSION_CLOCK,
                 pd: POWER_DOWN_PIN};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_ff <= '{cs_n: 1'b1, default: 1'b0};
      s2_ff <= '{cs_n: 1'b1, default: 1'b0};
      s3_ff <= '{cs_n: 1'b1, default: 1'b0};
    end else if (CE) begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  wire sel = !s2_ff.cs_n;
  wire cs_fall = s3_ff.cs_n && !s2_ff.cs_n;
  wire sclk_rise = sel && !s3_ff.sclk && s2_ff.sclk;
  wire sclk_fall = sel && s3_ff.sclk && !s2_ff.sclk;
  wire conversion_clock_rise = !s3_ff.conversion_clock && s2_ff.conversion_clock;

  sacp_pkg::sacp_state_e state_ff;
  sacp_pkg::sacp_state_e nxt_state;
  sacp_pkg::sacp_mode_s mode_ff;
  logic [`SACP_CMD_W-1:0] cmd_sr_ff;
  logic [`SACP_CNT_W-1:0] rx_cnt_ff;
  logic [`SACP_TMR_W-1:0] tmr_ff;
  logic [`SACP_TMR_W-1:0] nxt_tmr;
  logic sleep_ff;
  logic nxt_sleep;
  logic [`SACP_RES_W-1:0] result_ff;
  logic [`SACP_WORD_W-1:0] out_sr_ff;
  logic [`SACP_CNT_W-1:0] tx_left_ff;
  logic oe_ff;
  logic eoc_ff;
  logic ready_ff;

  // result fifo: an empty fifo holds the conversion in fetch
  logic [`SACP_RES_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_in_ready;
  wire fifo_pop = (state_ff == sacp_pkg::SACP_ST_FETCH);

  sacp_fifo #(
    .WIDTH(`SACP_RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .IN_DATA(SAMPLE_DATA),
    .IN_VALID(SAMPLE_VALID),
    .IN_READY(fifo_in_ready),
    .OUT_DATA(fifo_data),
    .OUT_VALID(fifo_valid),
    .OUT_READY(fifo_pop)
  );

  assign SAMPLE_READY = fifo_in_ready;

  // command reception
  wire [`SACP_CNT_W-1:0] word_len = len_of(mode_ff.len); // R3 R15 R16
  wire [`SACP_CNT_W-1:0] rx_next = rx_cnt_ff + `SACP_CNT_W'(1);
  wire rx_done = sclk_rise && (rx_next == word_len); // R20
  wire [`SACP_CMD_W-1:0] cmd_word = {cmd_sr_ff[`SACP_CMD_W-2:0], s2_ff.din};
  wire cmd_acc = rx_done && !s2_ff.pe_n && !s2_ff.pd &&
                 (state_ff == sacp_pkg::SACP_ST_IDLE); // R8
  wire sacp_pkg::sacp_mode_s new_mode = cmd_word;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_sr_ff <= '0;
      rx_cnt_ff <= '0;
      mode_ff <= '0; // R15
    end else if (CE) begin
      if (cs_fall || rx_done) begin
        rx_cnt_ff <= '0;
      end else if (sclk_rise) begin
        rx_cnt_ff <= rx_next;
      end
      if (sclk_rise && !s2_ff.pe_n) begin
        cmd_sr_ff <= cmd_word; // R4
      end
      if (cmd_acc) begin
        mode_ff <= new_mode;
      end
    end
  end

  // conversion, calibration and zeroing counted in conversion_clock edges
  wire [`SACP_TMR_W-1:0] busy_last =
    (mode_ff.op == sacp_pkg::SACP_OP_CAL) ? `SACP_TMR_W'(CAL_CCLKS - 1) :
    (mode_ff.op == sacp_pkg::SACP_OP_ZERO) ? `SACP_TMR_W'(ZERO_CCLKS - 1) :
    `SACP_TMR_W'(PROGRAM_ENABLE_N_CCLKS - 1);
  wire [`SACP_TMR_W-1:0] pwrup_last = `SACP_TMR_W'(PWRUP_CYCLES - 1);
  wire [`SACP_TMR_W-1:0] tmr_inc = tmr_ff + `SACP_TMR_W'(1);

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_sleep = sleep_ff && !cs_fall;
    case (state_ff)
      sacp_pkg::SACP_ST_IDLE: begin
        if (cmd_acc) begin
          nxt_tmr = '0;
          if (new_mode.op == sacp_pkg::SACP_OP_PDOWN) begin
            nxt_state = sacp_pkg::SACP_ST_PD;
            nxt_sleep = 1'b1;
          end else begin
            nxt_state = sacp_pkg::SACP_ST_BUSY;
          end
        end
      end
      sacp_pkg::SACP_ST_BUSY: begin
        if (cs_fall) begin
          nxt_state = sacp_pkg::SACP_ST_IDLE; // R13
        end else if (conversion_clock_rise) begin // R19
          if (tmr_ff == busy_last) begin
            nxt_state = (mode_ff.op == sacp_pkg::SACP_OP_PROGRAM_ENABLE_N) ?
                        sacp_pkg::SACP_ST_FETCH : sacp_pkg::SACP_ST_IDLE;
          end else begin
            nxt_tmr = tmr_inc;
          end
        end
      end
      sacp_pkg::SACP_ST_FETCH: begin
        if (fifo_valid) begin
          nxt_state = sacp_pkg::SACP_ST_IDLE;
        end
      end
      sacp_pkg::SACP_ST_PD: begin
        if (!s2_ff.pd && !nxt_sleep) begin
          nxt_state = sacp_pkg::SACP_ST_PWRUP;
          nxt_tmr = '0;
        end
      end
      sacp_pkg::SACP_ST_PWRUP: begin
        if (tmr_ff == pwrup_last) begin
          nxt_state = sacp_pkg::SACP_ST_IDLE; // R18
        end else begin
          nxt_tmr = tmr_inc;
        end
      end
      default: begin
        nxt_state = sacp_pkg::SACP_ST_IDLE;
      end
    endcase
    if (s2_ff.pd) begin
      nxt_state = sacp_pkg::SACP_ST_PD; // R18
    end
  end

  // eoc is high only in idle, so every cycle ends on its rise
  wire nxt_eoc = (nxt_state == sacp_pkg::SACP_ST_IDLE); // R5 R6
  wire eoc_rise = nxt_eoc && !eoc_ff;
  wire load = cs_fall || (eoc_rise && sel); // R10 R11
  wire [`SACP_RES_W-1:0] res_now = fifo_pop ? fifo_data : result_ff;
  wire last_fall = sclk_fall && (tx_left_ff == `SACP_CNT_W'(1));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= sacp_pkg::SACP_ST_IDLE;
      tmr_ff <= '0;
      sleep_ff <= 1'b0;
      eoc_ff <= 1'b1;
      result_ff <= '0;
    end else if (CE) begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      sleep_ff <= nxt_sleep;
      eoc_ff <= nxt_eoc;
      if (fifo_pop && fifo_valid) begin
        result_ff <= fifo_data;
      end
    end
  end

  // output shifter: first bit on load, the rest on sclk falls
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_sr_ff <= '0;
      tx_left_ff <= '0;
      oe_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else if (CE) begin
      oe_ff <= sel; // R1
      if (load) begin
        out_sr_ff <= frame(mode_ff, res_now); // R2 R3
        tx_left_ff <= word_len;
        ready_ff <= 1'b0; // R17
      end else if (sclk_fall && tx_left_ff != '0) begin
        out_sr_ff <= {out_sr_ff[`SACP_WORD_W-2:0], 1'b0}; // R2
        tx_left_ff <= tx_left_ff - `SACP_CNT_W'(1);
        if (last_fall) begin
          ready_ff <= 1'b1; // R17
        end
      end
    end
  end

  // a read-only access shifts the stored word and leaves the mode unchanged
  assign RESULT_O = out_sr_ff[`SACP_WORD_W-1]; // R8
  assign RESULT_OE = oe_ff; // R1
  assign EOC = eoc_ff; // R5
  assign OUTPUT_READY_FLAG = ready_ff;
endmodule : sacp_top

//--- bench/sacp_props.sv
// pin-level assertions for the converter control port
module sacp_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic PROGRAM_ENABLE_N,
  input wire logic POWER_DOWN_PIN,
  input wire logic RESULT_O,
  input wire logic RESULT_OE,
  input wire logic EOC,
  input wire logic OUTPUT_READY_FLAG
);
  default clocking @(posedge CLK); endclocking
  // a frozen block ignores its pins, so its windows are not judged
  default disable iff (!RST_N || !CE);
  // four samples leave room for the two-flop pin sync
  chk_oe_off: assert property (CS_N [*4] |-> !RESULT_OE)
    else $error("result driven while deselected");
  chk_oe_on: assert property (!CS_N [*4] |-> RESULT_OE)
    else $error("result not driven while selected");
  chk_result_hold: assert property (
    (SCLK && EOC) [*6] |-> $stable(RESULT_O))
    else $error("result bit moved while shift clock high");
  chk_pd_busy: assert property (POWER_DOWN_PIN [*4] |-> !EOC)
    else $error("eoc high while powered down");
  chk_pwrup_time: assert property (
    $fell(POWER_DOWN_PIN) |-> ##[1:200] EOC)
    else $error("power-up took too long");
  chk_eoc_cause: assert property (
    $fell(EOC) |-> !PROGRAM_ENABLE_N || POWER_DOWN_PIN)
    else $error("busy started in read-only access");
  chk_rd_only: assert property (
    (PROGRAM_ENABLE_N && !POWER_DOWN_PIN && EOC) [*5] |=> EOC)
    else $error("eoc fell with program enable high");
  chk_abort_idle: assert property (
    $fell(CS_N) && !EOC && !PROGRAM_ENABLE_N && !POWER_DOWN_PIN
    |-> ##[1:8] EOC)
    else $error("select fall did not abort conversion");
  chk_orf_fall: assert property (
    $fell(OUTPUT_READY_FLAG) |-> !CS_N && !$past(CS_N, 2))
    else $error("ready flag fell without selection");
  chk_orf_rise: assert property (
    $rose(OUTPUT_READY_FLAG) |-> !SCLK && !CS_N)
    else $error("ready flag rose outside a shift clock low");
  cover property ($rose(EOC));
  cover property ($rose(OUTPUT_READY_FLAG));
  cover property ($fell(CS_N) && !EOC && !PROGRAM_ENABLE_N);
  cover property ($rose(EOC) && !CS_N);
endmodule : sacp_props

bind sacp_top sacp_props i_sacp_props (.CLK, .RST_N, .CE, .CS_N, .SCLK,
  .PROGRAM_ENABLE_N, .POWER_DOWN_PIN, .RESULT_O, .RESULT_OE, .EOC,
  .OUTPUT_READY_FLAG);

//--- bench/sacp_host.sv
// host-side model that drives frames on the serial pins
module sacp_host (
  output logic cs_n,
  output logic sclk,
  output logic din,
  output logic pe_n,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    pe_n = 1'b1;
  end
  // the command sits in the last five bits, leading bits are zero
  task automatic xfer(input int n, input logic [4:0] cmd, input logic pe,
      output logic [16:0] rd);
    rd = 17'h0;
    pe_n = pe;
    #32;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = (i < 5) ? cmd[i] : 1'b0;
      #32;
      sclk = 1'b1;
      rd = {rd[15:0], dout};
      #32;
      sclk = 1'b0;
    end
    #32;
    cs_n = 1'b1;
    din = ~din;
  endtask : xfer
  // data read across an abort is not used
  task automatic set_cs(input logic v);
    #20;
    cs_n = v;
  endtask : set_cs
endmodule : sacp_host

//--- bench/tb.sv
// self-checking bench for the converter control port
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, ce, conversion_clock, pd, s_valid;
  logic [12:0] s_data;
  logic [16:0] rd;
  logic [12:0] words [8];
  wire cs_n, sclk, din, pe_n, s_ready, res, oe, eoc, orf;
  wire dout = oe ? res : 1'bz;
  int errors, checks_done, cycles, cur_len;

  sacp_top #(.PROGRAM_ENABLE_N_CCLKS(4), .CAL_CCLKS(6), .ZERO_CCLKS(5),
      .PWRUP_CYCLES(20)) i_sacp_top (.CLK(clk), .RST_N(rst_n), .CE(ce),
      .CS_N(cs_n), .SCLK(sclk), .COMMAND_IN_PIN(din),
      .PROGRAM_ENABLE_N(pe_n), .CONVERSION_CLOCK(conversion_clock),
      .POWER_DOWN_PIN(pd), .SAMPLE_DATA(s_data), .SAMPLE_VALID(s_valid),
      .SAMPLE_READY(s_ready), .RESULT_O(res), .RESULT_OE(oe), .EOC(eoc),
      .OUTPUT_READY_FLAG(orf));
  sacp_host i_sacp_host (.cs_n(cs_n), .sclk(sclk), .din(din),
      .pe_n(pe_n), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    conversion_clock = 1'b0;
    #7;
    forever #20 conversion_clock = ~conversion_clock;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string w, input logic [16:0] e,
      input logic [16:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic chk1(input string w, input logic e, input logic g);
    check(w, {16'h0, e}, {16'h0, g});
  endtask : chk1
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_eoc;
    for (int n = 0; n < 400 && eoc !== 1'b1; n++) tick;
    chk1("eoc done", 1'b1, eoc);
  endtask : wait_eoc
  task automatic push(input logic [12:0] d);
    tick;
    s_data = d;
    s_valid = 1'b1;
    tick;
    s_valid = 1'b0;
  endtask : push
  // 17-bit words carry op and length ahead of the result
  function automatic logic [16:0] exp_word(input logic [1:0] len,
      input logic lsb, input logic [12:0] w);
    logic [16:0] v, r;
    int n;
    n = (len == 2'h1) ? 17 : (len == 2'h2) ? 9 : 13;
    v = (len == 2'h1) ? {2'h0, len, w} :
        (len == 2'h2) ? {8'h0, w[12:4]} : {4'h0, w};
    r = 17'h0;
    for (int i = 0; i < n; i++) r[i] = v[n-1-i];
    return lsb ? r : v;
  endfunction : exp_word

  task automatic t_reset;
    tick;
    chk1("oe", 1'b0, oe);
    chk1("eoc", 1'b1, eoc);
    chk1("ready flag", 1'b1, orf);
    chk1("fifo ready", 1'b1, s_ready);
    $display("test reset done");
  endtask : t_reset
  // pins and fifo input move while frozen; nothing may be taken
  task automatic t_freeze;
    ce = 1'b0;
    pd = 1'b1;
    s_data = 13'h1555;
    s_valid = 1'b1;
    repeat (10) tick;
    chk1("frozen eoc", 1'b1, eoc);
    pd = 1'b0;
    s_valid = 1'b0;
    tick;
    ce = 1'b1;
    repeat (4) tick;
    chk1("eoc after freeze", 1'b1, eoc);
    chk1("fifo ready after freeze", 1'b1, s_ready);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_fill;
    for (int i = 0; i < 9; i++) begin
      if (i < 8) words[i] = 13'h0f0f ^ 13'(i * 13'h213);
      s_data = (i < 8) ? words[i] : 13'h1fff;
      s_valid = 1'b1;
      tick;
    end
    s_valid = 1'b0;
    chk1("fifo full", 1'b0, s_ready);
    $display("test fill done");
  endtask : t_fill
  task automatic t_modes;
    logic [4:0] cmd;
    for (int k = 0; k < 8; k++) begin
      cmd = {2'h0, k[0], k[2:1]};
      i_sacp_host.xfer(cur_len, cmd, 1'b0, rd);
      chk1("busy", 1'b0, eoc);
      wait_eoc;
      cur_len = (k[2:1] == 2'h1) ? 17 : (k[2:1] == 2'h2) ? 9 : 13;
      i_sacp_host.xfer(cur_len, 5'h1f, 1'b1, rd);
      check("word", exp_word(k[2:1], k[0], words[k]), rd);
      chk1("no start", 1'b1, eoc);
      chk1("ready flag", 1'b1, orf);
    end
    $display("test modes done");
  endtask : t_modes
  task automatic t_empty;
    i_sacp_host.xfer(cur_len, 5'h00, 1'b0, rd);
    repeat (60) tick;
    chk1("stall", 1'b0, eoc);
    push(13'h0abc);
    wait_eoc;
    i_sacp_host.xfer(13, 5'h1f, 1'b1, rd);
    check("late word", 17'h0abc, rd);
    $display("test empty done");
  endtask : t_empty
  task automatic t_ops;
    for (int op = 1; op < 4; op++) begin
      i_sacp_host.xfer(13, {op[1:0], 3'h0}, 1'b0, rd);
      chk1("op busy", 1'b0, eoc);
      if (op == 3) i_sacp_host.xfer(13, 5'h00, 1'b1, rd);
      wait_eoc;
    end
    $display("test ops done");
  endtask : t_ops
  task automatic t_pin;
    tick;
    pd = 1'b1;
    repeat (10) tick;
    chk1("pd", 1'b0, eoc);
    tick;
    pd = 1'b0;
    wait_eoc;
    $display("test pin done");
  endtask : t_pin
  task automatic t_abort;
    push(13'h0123);
    i_sacp_host.xfer(13, 5'h00, 1'b0, rd);
    chk1("abort busy", 1'b0, eoc);
    i_sacp_host.set_cs(1'b0);
    repeat (8) tick;
    chk1("abort", 1'b1, eoc);
    i_sacp_host.set_cs(1'b1);
    $display("test abort done");
  endtask : t_abort

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    pd = 1'b0;
    s_valid = 1'b0;
    s_data = 13'h0;
    cur_len = 13;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_freeze;
    t_fill;
    t_modes;
    t_empty;
    t_ops;
    t_pin;
    t_abort;
    give_verdict;
  end
endmodule : tb
